/* logic/eiw_ext_irq_wake.v */
`timescale 1ns/1ps
`include "eiw_consts.vh"

module eiw_ext_irq_wake #(
  parameter NUM_IRQ = `EIW_NUM_IRQ,
  parameter ADDR_W = `EIW_ADDR_W,
  parameter DATA_W = `EIW_DATA_W
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [NUM_IRQ-1:0] i_pin_irq_n,
  input wire [NUM_IRQ-1:0] i_pin_routed,
  input wire i_power_down,
  input wire [ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [DATA_W-1:0] o_rdata,
  output wire [NUM_IRQ-1:0] o_vic_irq,
  output wire o_wakeup,
  output wire o_irq
);

  // ****************************************
  // helper functions
  // ****************************************

  // exact match on the full byte address; a partial decode would alias
  function addr_hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] base;

    begin
      addr_hit = (addr == base);
    end
  endfunction

  // kept as a function so the wake and irq paths combine lanes alike
  function any_set;
    input [NUM_IRQ-1:0] lanes;
    integer k;

    begin
      any_set = 1'h0;
      for (k = 0; k < NUM_IRQ; k = k + 1) begin
        any_set = any_set | lanes[k];
      end
    end
  endfunction

  // write one to clear; the event is or-ed in last so a same-cycle set wins
  function [NUM_IRQ-1:0] w1c_next;
    input [NUM_IRQ-1:0] cur;
    input wr_en;
    input [NUM_IRQ-1:0] clr;
    input [NUM_IRQ-1:0] set;
    reg [NUM_IRQ-1:0] tmp;

    begin
      tmp = cur;
      if (wr_en) begin
        tmp = tmp & ~clr;
      end
      w1c_next = tmp | set;
    end
  endfunction

  // reserved upper bits read as zero rather than left undefined
  function [DATA_W-1:0] pad_rd;
    input [NUM_IRQ-1:0] val;

    begin
      pad_rd = {`EIW_RSVD_PAD, val};
    end
  endfunction



  // ****************************************
  // pin synchronisers
  // ****************************************

  // pins are asynchronous; the first stage feeds only the second
  reg [NUM_IRQ-1:0] sync1_reg;
  reg [NUM_IRQ-1:0] sync2_reg;

  // reset to the idle high level so no false set follows reset
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= `EIW_SYNC_RST;
    end else begin
      sync1_reg <= i_pin_irq_n;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync2_reg <= `EIW_SYNC_RST;
    end else begin
      sync2_reg <= sync1_reg;
    end
  end

  // routing selects come from same-clock pin-function logic, no sync needed
  wire [NUM_IRQ-1:0] pin_low;

  // active low, and only meaningful when routed to the pin
  assign pin_low = ~sync2_reg & i_pin_routed;



  // ****************************************
  // register decode
  // ****************************************

  // write selects
  wire wr_flags;
  wire wr_wake;
  wire wr_mask;
  wire wr_stat;

  assign wr_flags = i_wr && addr_hit(i_addr, `EIW_OFF_FLAGS);
  assign wr_wake = i_wr && addr_hit(i_addr, `EIW_OFF_WAKE);
  assign wr_mask = i_wr && addr_hit(i_addr, `EIW_OFF_IRQ_MASK);
  assign wr_stat = i_wr && addr_hit(i_addr, `EIW_OFF_STATUS);

  // read selects
  wire rd_flags;
  wire rd_wake;
  wire rd_mask;
  wire rd_stat;

  assign rd_flags = i_rd && addr_hit(i_addr, `EIW_OFF_FLAGS);
  assign rd_wake = i_rd && addr_hit(i_addr, `EIW_OFF_WAKE);
  assign rd_mask = i_rd && addr_hit(i_addr, `EIW_OFF_IRQ_MASK);
  assign rd_stat = i_rd && addr_hit(i_addr, `EIW_OFF_STATUS);

  // bits 7:3 of a write are dropped; software should keep them zero
  wire [NUM_IRQ-1:0] wr_bits;
  assign wr_bits = i_wdata[NUM_IRQ-1:0];



  // ****************************************
  // flag register
  // ****************************************

  reg [NUM_IRQ-1:0] flags_reg;
  reg [NUM_IRQ-1:0] flags_next;
  wire [NUM_IRQ-1:0] flag_set;
  wire [NUM_IRQ-1:0] flag_clr;

  assign flag_set = pin_low;
  // a low routed pin masks its own clear, so the flag stays while it is low
  assign flag_clr = wr_bits & ~pin_low;

  always @* begin
    flags_next = w1c_next(flags_reg, wr_flags, flag_clr, flag_set);
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg <= `EIW_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end



  // ****************************************
  // wake enable register
  // ****************************************

  reg [NUM_IRQ-1:0] wake_reg;
  reg [NUM_IRQ-1:0] wake_next;

  always @* begin
    wake_next = wake_reg;

    if (wr_wake) begin
      wake_next = wr_bits;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_reg <= `EIW_WAKE_RST;
    end else begin
      wake_reg <= wake_next;
    end
  end



  // ****************************************
  // interrupt mask register
  // ****************************************

  reg [NUM_IRQ-1:0] mask_reg;
  reg [NUM_IRQ-1:0] mask_next;

  always @* begin
    mask_next = mask_reg;

    if (wr_mask) begin
      mask_next = wr_bits;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_reg <= `EIW_MASK_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end



  // ****************************************
  // status register
  // ****************************************

  // sticky event bits: a rising flag sets, write one clears
  reg [NUM_IRQ-1:0] stat_reg;
  reg [NUM_IRQ-1:0] stat_next;
  reg [NUM_IRQ-1:0] flags_prev_reg;
  wire [NUM_IRQ-1:0] flag_rise;

  assign flag_rise = flags_reg & ~flags_prev_reg;

  always @* begin
    stat_next = w1c_next(stat_reg, wr_stat, wr_bits, flag_rise);
  end

  // flags of the cycle before, to find the rising edge
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_prev_reg <= `EIW_FLAGS_RST;
    end else begin
      flags_prev_reg <= flags_reg;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_reg <= `EIW_FLAGS_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end



  // ****************************************
  // read data
  // ****************************************

  // each register as the bus sees it
  wire [DATA_W-1:0] flags_rd;
  wire [DATA_W-1:0] wake_rd;
  wire [DATA_W-1:0] mask_rd;
  wire [DATA_W-1:0] stat_rd;

  assign flags_rd = pad_rd(flags_reg);
  assign wake_rd = pad_rd(wake_reg);
  assign mask_rd = pad_rd(mask_reg);
  assign stat_rd = pad_rd(stat_reg);

  // zero outside a read, so the bus never sees stale data
  reg [DATA_W-1:0] rdata_next;

  always @* begin
    rdata_next = `EIW_RDATA_RST;

    if (rd_flags) begin
      rdata_next = flags_rd;
    end else if (rd_wake) begin
      rdata_next = wake_rd;
    end else if (rd_mask) begin
      rdata_next = mask_rd;
    end else if (rd_stat) begin
      rdata_next = stat_rd;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `EIW_RDATA_RST;
    end else begin
      o_rdata <= rdata_next;
    end
  end



  // ****************************************
  // wakeup request
  // ****************************************

  // controller enables are not seen here, so they cannot gate the wakeup
  wire [NUM_IRQ-1:0] wake_src;
  wire wake_any;

  assign wake_src = pin_low & wake_reg;
  assign wake_any = any_set(wake_src);

  // combinational so power control sees it without a clock; only while asleep
  assign o_wakeup = i_power_down && wake_any;



  // ****************************************
  // interrupt outputs
  // ****************************************

  // summary interrupt from status and mask
  wire [NUM_IRQ-1:0] irq_pend;

  assign irq_pend = stat_reg & mask_reg;
  assign o_irq = any_set(irq_pend);

  // flags go out as plain levels; the controller applies its own enables
  assign o_vic_irq = flags_reg;

endmodule // eiw_ext_irq_wake

/* include/eiw_consts.vh */
`ifndef EIW_CONSTS_VH
`define EIW_CONSTS_VH
// ****************************************
// register map (byte addresses)
// ****************************************
`define EIW_ADDR_W 32
`define EIW_DATA_W 8
`define EIW_OFF_FLAGS 32'hE01FC140
`define EIW_OFF_WAKE 32'hE01FC144
`define EIW_OFF_IRQ_MASK 32'hE01FC148
`define EIW_OFF_STATUS 32'hE01FC14C
// ****************************************
// field layout and reset values
// ****************************************
`define EIW_NUM_IRQ 3
`define EIW_FLAGS_RST 3'h0
`define EIW_WAKE_RST 3'h0
`define EIW_MASK_RST 3'h0
`define EIW_RSVD_PAD 5'h00
`define EIW_SYNC_RST 3'h7
`define EIW_RDATA_RST 8'h00
`define EIW_STAT_PAD 4'h0
`endif

/* dv/eiw_ext_irq_wake_assertions.sv */
`timescale 1ns/1ps
module eiw_chk (
  input wire i_clk,
  input wire i_rst_n,
  input wire [2:0] i_pin_irq_n,
  input wire [2:0] i_pin_routed,
  input wire i_power_down,
  input wire [31:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire [2:0] o_vic_irq,
  input wire o_wakeup
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_WPD: assert property (o_wakeup |-> i_power_down) else $error("wake outside power down");
  AST_WRT: assert property (o_wakeup |-> |i_pin_routed) else $error("wake with nothing routed");
  AST_WLOW: assert property (o_wakeup |-> |(i_pin_routed & ~$past(i_pin_irq_n, 2))) else $error("wake no pin");
  AST_SET: assert property ((!i_pin_irq_n[0] && i_pin_routed[0])[*3] |=> o_vic_irq[0]) else $error("no set");
  AST_FALL: assert property ($fell(o_vic_irq[0]) && $past(i_rst_n) |->
    $past(i_wr && i_addr == 32'hE01FC140 && i_wdata[0])) else $error("flag lost");
  AST_STAY: assert property (o_vic_irq[1] && !i_wr |=> o_vic_irq[1]) else $error("flag not sticky");
  AST_RDI: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("idle read data");
  AST_RSV: assert property ($past(i_rd) |-> o_rdata[7:3] == 5'h00) else $error("reserved bits set");
endmodule // eiw_chk
bind eiw_ext_irq_wake eiw_chk eiw_chk_i (.*);

/* dv/eiw_pin_model.sv */
`timescale 1ns/1ps
module eiw_pin_model (
  input wire i_clk,
  input wire [2:0] i_assert,
  output reg [2:0] o_pin_irq_n
);
  // pins idle high, like a pulled-up line
  initial o_pin_irq_n = 3'h7;
  always @(posedge i_clk) o_pin_irq_n <= ~i_assert;
endmodule // eiw_pin_model

/* dv/tb_eiw_ext_irq_wake.sv */
`timescale 1ns/1ps
module tb_eiw_ext_irq_wake;
  reg i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_power_down = 0;
  reg [2:0] asrt = 0, i_pin_routed = 0;
  reg [31:0] i_addr = 0;
  reg [7:0] i_wdata = 0;
  wire [2:0] pin_n, vectored_irq_controller;
  wire [7:0] o_rdata;
  wire wake, irq;
  integer miscompares = 0, checked = 0, n;
  eiw_pin_model eiw_pin_model_i (.i_clk(i_clk), .i_assert(asrt), .o_pin_irq_n(pin_n));
  eiw_ext_irq_wake eiw_ext_irq_wake_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin_irq_n(pin_n),
    .i_pin_routed(i_pin_routed), .i_power_down(i_power_down), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_vic_irq(vectored_irq_controller), .o_wakeup(wake), .o_irq(irq));
  initial forever #20 i_clk = ~i_clk;
  task ck(input [7:0] g, input [7:0] e); begin
    checked = checked + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  end endtask
  task wr(input [31:0] a, input [7:0] d); begin
    @(posedge i_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_clk) i_wr <= 0;
  end endtask
  task rd(input [31:0] a, input [7:0] e); begin
    @(posedge i_clk) {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_clk) i_rd <= 0;
    #1 ck(o_rdata, e);
  end endtask
  task t_flag(input integer k); begin
    @(posedge i_clk) asrt <= 3'h1 << k;
    repeat (4) @(posedge i_clk);
    rd(32'hE01FC140, 8'h01 << k);
    ck(vectored_irq_controller, 8'h01 << k);
    ck(irq, 0);
    wr(32'hE01FC148, 8'h01 << k);
    #1 ck(irq, 1);
    wr(32'hE01FC140, 8'h07);
    rd(32'hE01FC140, 8'h01 << k);
    @(posedge i_clk) asrt <= 0;
    repeat (4) @(posedge i_clk);
    wr(32'hE01FC140, 8'h01 << k);
    rd(32'hE01FC140, 8'h00);
    wr(32'hE01FC14C, 8'h07);
    wr(32'hE01FC148, 8'h00);
    #1 ck(irq, 0);
    $display("flag %0d done", k);
  end endtask
  task t_wake; begin
    wr(32'hE01FC144, 8'h01);
    rd(32'hE01FC144, 8'h01);
    @(posedge i_clk) {i_power_down, i_pin_routed, asrt} <= {1'b1, 3'h6, 3'h1};
    repeat (5) @(posedge i_clk);
    #1 ck(wake, 0);
    rd(32'hE01FC140, 8'h00);
    @(posedge i_clk) i_pin_routed <= 3'h7;
    #1 ck(wake, 1);
    @(posedge i_clk) i_power_down <= 0;
    #1 ck(wake, 0);
    @(posedge i_clk) i_power_down <= 1;
    @(posedge i_clk) asrt <= 3'h2;
    repeat (5) @(posedge i_clk);
    #1 ck(wake, 0);
    @(posedge i_clk) {i_power_down, asrt} <= 0;
    repeat (4) @(posedge i_clk);
    wr(32'hE01FC140, 8'h07);
    $display("wake done");
  end endtask
  task give_verdict; begin
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end endtask
  initial begin
    #100000;
    miscompares = miscompares + 1;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge i_clk);
    {i_rst_n, i_pin_routed} <= 4'hF;
    rd(32'hE01FC140, 8'h00);
    rd(32'hE01FC144, 8'h00);
    rd(32'hE01FC150, 8'h00);
    for (n = 0; n < 3; n = n + 1) t_flag(n);
    t_wake;
    give_verdict;
  end
endmodule // tb_eiw_ext_irq_wake
